// ==== hw/msp_serial_port.sv ====
// How it works
// - Power-up or select fall gives command mode
// - Command is 8 bits: direction, 6-bit address
// - Last register bit moved returns command mode
// - Input bits sampled on serial clock fall
// - Output bits presented on serial clock rise
// - Select falling edge resets port to command
// - Select high aborts and releases output
// - Link timing follows serial clock only
// - Ones count cleared before first read bit
// - Each read bit sent adds into count
// - Reading the count is itself counted
// - Writes bytewise, MSB byte first, partial dropped
// - Whole register captured at read command
// - Output drives first rise, releases last fall
`timescale 1ns/10ps
module msp_serial_port #(
  parameter int FIFO_DEPTH = msp_pkg::FIFO_DEPTH
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        sclk,
  input  wire logic                        din,
  input  wire logic                        cs_n,
  output logic                             dout,
  output logic                             dout_oe_n,
  output logic [msp_pkg::ADDR_W-1:0]       acc_addr,
  input  wire logic [msp_pkg::LEN_W-1:0]   reg_len_bytes,
  output logic                             rd_req,
  input  wire logic [msp_pkg::WORD_W-1:0]  rd_data,
  output logic                             wr_valid,
  input  wire logic                        wr_ready,
  output msp_pkg::msp_wr_byte_s            wr_byte,
  output logic [msp_pkg::CKSUM_W-1:0]      read_ones_sum
);

  logic [2:0]                     pins_s;         // Synchronised cs_n, sclk, din
  logic                           cs_n_s;         // Select after sync
  logic                           sclk_s;         // Serial clock after sync
  logic                           din_s;          // Data in after sync
  logic                           sclk_prev_reg;  // Serial clock one cycle back
  logic                           cs_n_prev_reg;  // Select one cycle back
  logic                           sclk_rise;      // Rising serial clock seen
  logic                           sclk_fall;      // Falling serial clock seen
  logic                           cs_fall;        // Select just asserted
  logic                           selected;       // Select held low
  msp_pkg::msp_state_e            state_reg;      // Port state
  msp_pkg::msp_state_e            state_next;
  logic [msp_pkg::BITCNT_W-1:0]   bit_cnt_reg;    // Bit index in current byte
  logic [msp_pkg::BYTE_W-1:0]     byte_sh_reg;    // Incoming byte shifter
  logic [msp_pkg::BYTE_W-1:0]     full_byte;      // Byte completed at this fall
  logic                           byte_done;      // Eighth bit sampled now
  logic [msp_pkg::BYTE_W-1:0]     cmd_reg;        // Transfer command
  logic [msp_pkg::LEN_W-1:0]      len_reg;        // Target length in bytes
  logic [msp_pkg::LEN_W-1:0]      len_eff;        // Length with zero forced to one
  logic [msp_pkg::LEN_W-1:0]      byte_idx_reg;   // Write byte number
  logic [msp_pkg::WORD_W-1:0]     shift_reg;      // Outgoing read data
  logic [msp_pkg::WORD_W-1:0]     rd_word;        // Source value for a read
  logic [msp_pkg::WORD_W-1:0]     rd_aligned;     // Source value, first bit on top
  logic [msp_pkg::BITS_W-1:0]     rd_bits_reg;    // Read bits still to send
  logic [msp_pkg::CKSUM_W-1:0]    cksum_reg;      // Ones sent in last read
  logic                           dout_reg;       // Output bit
  logic                           oe_n_reg;       // Output enable, low drives
  logic                           push_valid_reg; // Byte waiting for the FIFO
  msp_pkg::msp_wr_byte_s          push_reg;       // Byte held for the FIFO
  logic                           push_ready;     // FIFO has room
  logic                           is_write;       // Command selects a write
  logic                           send_bit;       // Shift one read bit now
  logic                           read_last;      // Falling edge ends the read

  // Pins cross into the clock domain; sclk is sampled, never used as a clock
  msp_sync #(
    .W    (3),
    .INIT (3'h6)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({cs_n, sclk, din}),
    .q     (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  // Edge history of the synchronised pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'b1;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_n_prev_reg <= cs_n_s;
    end
  end

  // Edge detection, the only timing reference of the link
  assign sclk_rise = sclk_s && !sclk_prev_reg;
  assign sclk_fall = !sclk_s && sclk_prev_reg;
  assign cs_fall   = !cs_n_s && cs_n_prev_reg;
  assign selected  = !cs_n_s;

  // Decode helpers
  assign full_byte = {byte_sh_reg[msp_pkg::BYTE_W-2:0], din_s};
  assign byte_done = sclk_fall && (bit_cnt_reg == msp_pkg::LAST_BIT);
  assign is_write  = cmd_reg[msp_pkg::CMD_DIR_BIT];
  assign len_eff   = (reg_len_bytes == '0) ? 2'h1 : reg_len_bytes;
  assign send_bit  = (state_reg == msp_pkg::ST_RD) && sclk_rise && (rd_bits_reg != '0);
  assign read_last = (state_reg == msp_pkg::ST_RD) && sclk_fall && (rd_bits_reg == '0);

  // Reading the count returns its present value, then restarts it
  assign rd_word = (cmd_reg[msp_pkg::ADDR_W-1:0] == msp_pkg::CKSUM_ADDR) ?
                   {{(msp_pkg::WORD_W-msp_pkg::CKSUM_W){1'b0}}, cksum_reg} :
                   rd_data;

  // Right-justified value moved so its first bit sits on top
  always_comb begin
    case (len_eff)
      2'h1: begin
        rd_aligned = {rd_word[7:0], 16'h0000};
      end
      2'h2: begin
        rd_aligned = {rd_word[15:0], 8'h00};
      end
      default: begin
        rd_aligned = rd_word;
      end
    endcase
  end

  // Target lookup toward the register core
  assign acc_addr = cmd_reg[msp_pkg::ADDR_W-1:0];
  assign rd_req   = (state_reg == msp_pkg::ST_DECODE) && !is_write;

  // Next state
  always_comb begin
    state_next = state_reg;
    if (!selected) begin
      state_next = msp_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_next = msp_pkg::ST_CMD;
    end else begin
      case (state_reg)
        msp_pkg::ST_IDLE: begin
          state_next = msp_pkg::ST_CMD;
        end
        msp_pkg::ST_CMD: begin
          if (byte_done) begin
            state_next = msp_pkg::ST_DECODE;
          end
        end
        msp_pkg::ST_DECODE: begin
          state_next = is_write ? msp_pkg::ST_WR : msp_pkg::ST_RD;
        end
        msp_pkg::ST_WR: begin
          if (byte_done && (byte_idx_reg == len_reg - 2'h1)) begin
            state_next = msp_pkg::ST_CMD;
          end
        end
        msp_pkg::ST_RD: begin
          if (read_last) begin
            state_next = msp_pkg::ST_CMD;
          end
        end
        default: begin
          state_next = msp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // State register; device reset lands in command mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= msp_pkg::ST_CMD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Byte assembly on falling serial clock; a cut byte never completes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_reg <= '0;
      byte_sh_reg <= '0;
    end else if (!selected || cs_fall || (state_next != state_reg)) begin
      bit_cnt_reg <= '0;
    end else if (sclk_fall &&
                 ((state_reg == msp_pkg::ST_CMD) || (state_reg == msp_pkg::ST_WR))) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      byte_sh_reg <= full_byte;
    end
  end

  // Command capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_reg <= '0;
    end else if ((state_reg == msp_pkg::ST_CMD) && byte_done && selected && !cs_fall) begin
      cmd_reg <= full_byte;
    end
  end

  // Length and write byte number
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      len_reg      <= 2'h1;
      byte_idx_reg <= '0;
    end else if (state_reg == msp_pkg::ST_DECODE) begin
      len_reg      <= len_eff;
      byte_idx_reg <= '0;
    end else if ((state_reg == msp_pkg::ST_WR) && byte_done) begin
      byte_idx_reg <= byte_idx_reg + 2'h1;
    end
  end

  // Completed write bytes wait here until the FIFO takes them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      push_valid_reg <= 1'b0;
      push_reg       <= '0;
    end else if ((state_reg == msp_pkg::ST_WR) && byte_done && selected && !cs_fall) begin
      push_valid_reg <= 1'b1;
      push_reg       <= '{addr: acc_addr, idx: byte_idx_reg, data: full_byte};
    end else if (push_ready) begin
      push_valid_reg <= 1'b0;
    end
  end

  // Read path: capture whole register, then shift out on rising edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_reg   <= msp_pkg::WORD_RESET;
      rd_bits_reg <= '0;
      dout_reg    <= 1'b0;
    end else if (rd_req) begin
      shift_reg   <= rd_aligned;
      rd_bits_reg <= {len_eff, 3'b000};
    end else if (send_bit && selected) begin
      dout_reg    <= shift_reg[msp_pkg::WORD_W-1];
      shift_reg   <= {shift_reg[msp_pkg::WORD_W-2:0], 1'b0};
      rd_bits_reg <= rd_bits_reg - 5'h01;
    end
  end

  // Ones count of the bits sent
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cksum_reg <= msp_pkg::CKSUM_RESET;
    end else if (rd_req) begin
      cksum_reg <= msp_pkg::CKSUM_RESET;
    end else if (send_bit && selected) begin
      cksum_reg <= cksum_reg + {{(msp_pkg::CKSUM_W-1){1'b0}},
                                shift_reg[msp_pkg::WORD_W-1]};
    end
  end

  // Output enable: on at first rise of a read, off at last fall or deselect
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_n_reg <= 1'b1;
    end else if (!selected || read_last) begin
      oe_n_reg <= 1'b1;
    end else if (send_bit) begin
      oe_n_reg <= 1'b0;
    end
  end

  assign dout          = dout_reg;
  assign dout_oe_n     = oe_n_reg;
  assign read_ones_sum = cksum_reg;

  // Write bytes toward the register core
  msp_fifo #(
    .W     (msp_pkg::WR_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push_valid_reg),
    .in_ready  (push_ready),
    .in_data   (push_reg),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_byte)
  );

  // Checks
  csfall_to_cmd_a: assert property (@(posedge clock) disable iff (rst)
    cs_fall && selected |=> state_reg == msp_pkg::ST_CMD)
    else $error("select fall did not restart command mode");

  desel_release_a: assert property (@(posedge clock) disable iff (rst)
    !selected |=> dout_oe_n && state_reg == msp_pkg::ST_IDLE)
    else $error("deselect did not release output");

  cksum_clear_a: assert property (@(posedge clock) disable iff (rst)
    rd_req |=> cksum_reg == '0 && rd_bits_reg == {$past(len_eff), 3'b000})
    else $error("count not cleared at read start");

  cksum_add_a: assert property (@(posedge clock) disable iff (rst)
    send_bit && selected |=>
      cksum_reg == $past(cksum_reg) + {5'h00, $past(shift_reg[msp_pkg::WORD_W-1])})
    else $error("count missed a sent bit");

  drive_on_rise_a: assert property (@(posedge clock) disable iff (rst)
    $fell(dout_oe_n) |-> $past(sclk_rise) && $past(state_reg) == msp_pkg::ST_RD)
    else $error("output driven without rising edge");

  sample_on_fall_a: assert property (@(posedge clock) disable iff (rst)
    bit_cnt_reg != '0 && $changed(bit_cnt_reg) |-> $past(sclk_fall))
    else $error("bit taken without falling edge");

  read_end_a: assert property (@(posedge clock) disable iff (rst)
    read_last && selected && !cs_fall |=> state_reg == msp_pkg::ST_CMD && dout_oe_n)
    else $error("read end did not return to command");

  dir_decode_a: assert property (@(posedge clock) disable iff (rst)
    state_reg == msp_pkg::ST_DECODE && selected && !cs_fall |=>
      state_reg == (is_write ? msp_pkg::ST_WR : msp_pkg::ST_RD))
    else $error("command direction misdecoded");

  capture_whole_a: assert property (@(posedge clock) disable iff (rst)
    rd_req |=> shift_reg == $past(rd_aligned))
    else $error("read word not captured whole");

  cmd_eight_a: assert property (@(posedge clock) disable iff (rst)
    state_reg == msp_pkg::ST_DECODE |-> $past(state_reg) == msp_pkg::ST_CMD
      && $past(bit_cnt_reg) == msp_pkg::LAST_BIT && $past(sclk_fall))
    else $error("command shorter than eight bits");

endmodule

// ==== hw/msp_pkg.sv ====
package msp_pkg;

  // Link field widths
  localparam int BYTE_W      = 8;             // Bits per serial byte
  localparam int ADDR_W      = 6;             // Register address width
  localparam int CKSUM_W     = 6;             // Ones-count register width
  localparam int LEN_W       = 2;             // Register length in bytes, 1..3
  localparam int MAX_BYTES   = 3;             // Widest register in bytes
  localparam int WORD_W      = MAX_BYTES * BYTE_W;  // Read capture width
  localparam int BITS_W      = 5;             // Remaining read bit count width
  localparam int BITCNT_W    = 3;             // Bit index within a byte

  // Command byte layout
  localparam int CMD_DIR_BIT = 7;             // One means write, zero means read
  localparam logic [BITCNT_W-1:0] LAST_BIT = 3'h7;  // Index of a byte's final bit

  // Ones-count register address
  localparam logic [ADDR_W-1:0] CKSUM_ADDR = 6'h3e;

  // Reset values
  localparam logic [CKSUM_W-1:0] CKSUM_RESET = 6'h00;
  localparam logic [WORD_W-1:0]  WORD_RESET  = 24'h000000;

  // Buffering
  localparam int FIFO_DEPTH  = 4;             // Write bytes held toward the core
  localparam int SYNC_STAGES = 2;             // Pin synchroniser depth

  // Port states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,                       // Deselected, output released
    ST_CMD    = 3'b001,                       // Shifting in a command byte
    ST_DECODE = 3'b010,                       // One cycle to look up the target
    ST_WR     = 3'b011,                       // Shifting in write data
    ST_RD     = 3'b100                        // Shifting out read data
  } msp_state_e;

  // One written byte on its way to the register core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;                  // Target register
    logic [LEN_W-1:0]  idx;                   // Byte number, 0 is most significant
    logic [BYTE_W-1:0] data;                  // Byte value
  } msp_wr_byte_s;

  localparam int WR_BYTE_W = $bits(msp_wr_byte_s);

endpackage

// ==== hw/msp_sync.sv ====
`timescale 1ns/10ps
// Multi-bit two-flop synchroniser for slow independent pins
module msp_sync #(
  parameter int                W      = 1,
  parameter logic [W-1:0]      INIT   = '0
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [W-1:0]    d,
  output logic      [W-1:0]    q
);

  logic [W-1:0] meta_reg;                    // First stage, read only by second

  // Two stages, both reset to the idle pin levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ==== hw/msp_fifo.sv ====
`timescale 1ns/10ps
// Small synchronous FIFO with valid and ready on both sides
module msp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];                // Storage
  logic [PW-1:0] wr_ptr_reg;                 // Next slot to fill
  logic [PW-1:0] rd_ptr_reg;                 // Oldest slot
  logic [PW:0]   count_reg;                  // Words held
  logic          push;
  logic          pop;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule

// ==== test/msp_host_model.sv ====
`timescale 1ns/10ps
// Bus master model: drives the link pins from the system clock
module msp_host_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      din,
  output logic      cs_n,
  input  wire logic miso
);
  // Idle: deselected, serial clock parked low between frames
  initial begin
    sclk = 1'b0;
    din  = 1'b0;
    cs_n = 1'b1;
  end

  // Select on or off; a released data line shows the inverse of its last bit
  task automatic sel(input logic on);
    @(posedge clock);
    cs_n <= ~on;
    if (!on) begin
      din <= ~din;
    end
    repeat (6) @(posedge clock);
  endtask

  // One bit: rise launches the read bit, fall takes din, read bit picked up late
  task automatic xbit(input logic b, output logic r);
    @(posedge clock);
    sclk <= 1'b1;
    din  <= b;
    repeat (4) @(posedge clock);
    sclk <= 1'b0;
    repeat (2) @(posedge clock);
    r = miso;
    @(posedge clock);
  endtask

  // Whole byte, most significant bit first
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], rx[i]);
    end
  endtask

  // Command byte then n data bytes; write bytes spaced by 4 us (200 clocks)
  task automatic access(input logic wr, input logic [5:0] a, input int n,
                        input logic [23:0] wd, output logic [23:0] rd);
    logic [7:0] b;
    rd = '0;
    xbyte({wr, 1'b0, a}, b);
    for (int k = n - 1; k >= 0; k--) begin
      xbyte(wr ? wd[k*8 +: 8] : 8'h00, b);
      rd[k*8 +: 8] = b;
      if (wr) begin
        repeat (200) @(posedge clock);
      end
    end
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic                       clock, rst, wr_ready, rd_req, wr_valid;
  logic                       sclk, din, cs_n, dout, dout_oe_n;
  wire                        miso;        // Data line as the host sees it
  logic [5:0]                 acc_addr;
  logic [1:0]                 core_len;    // Length the core reports
  logic [23:0]                core_val;    // Value the core holds
  logic [23:0]                rd_data, rx;
  logic [5:0]                 read_ones_sum, exp_sum;
  msp_pkg::msp_wr_byte_s      wr_byte;
  msp_pkg::msp_wr_byte_s      got[$];      // Bytes the core accepted
  logic [15:0]                exp_w [4];
  logic [7:0]                 b;
  int                         err_count, compares, base;

  // Released output floats so a stale bit cannot pass
  assign miso = dout_oe_n ? 1'bz : dout;
  // Core answers correctly only in the request cycle
  assign rd_data = rd_req ? core_val : ~core_val;

  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  msp_serial_port i_msp_serial_port (
    .clock(clock), .rst(rst), .sclk(sclk), .din(din), .cs_n(cs_n),
    .dout(dout), .dout_oe_n(dout_oe_n), .acc_addr(acc_addr),
    .reg_len_bytes(core_len), .rd_req(rd_req), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_byte(wr_byte),
    .read_ones_sum(read_ones_sum)
  );

  msp_host_model i_msp_host_model (
    .clock(clock), .sclk(sclk), .din(din), .cs_n(cs_n), .miso(miso)
  );

  // Record every byte handed to the core
  always @(posedge clock) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      got.push_back(wr_byte);
    end
  end

  // Verdict and end of run
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and report
  task automatic check(input logic [23:0] act, input logic [23:0] exp, input string what);
    compares++;
    if (act !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask

  // One access with the core set up for it
  task automatic acc(input logic wr, input logic [5:0] a, input logic [1:0] n,
                     input logic [23:0] v);
    @(posedge clock);
    core_len <= n;
    core_val <= v;
    i_msp_host_model.access(wr, a, int'(n), v, rx);
  endtask

  // Bounded wait for accepted bytes
  task automatic wait_got(input int n);
    int t;
    t = 0;
    while (got.size() < n && t < 300) begin
      @(posedge clock);
      t++;
    end
    if (got.size() < n) begin
      err_count++;
      $display("unexpected at %0t: no bytes reached the core", $time);
      results();
    end
  endtask

  initial begin
    rst = 1'b1;
    wr_ready = 1'b0;
    core_len = 2'h1;
    core_val = '0;
    err_count = 0;
    compares = 0;
    exp_w = '{{6'h21, 2'h0, 8'h12}, {6'h21, 2'h1, 8'h34}, {6'h21, 2'h2, 8'h56},
              {6'h0a, 2'h0, 8'hc9}};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check(dout_oe_n, 1'b1, "output at reset");
    check(read_ones_sum, 6'h00, "sum at reset");
    check(wr_valid, 1'b0, "valid at reset");
    $display("test reset done");

    // Three-byte read, then back-to-back reads with select held low
    i_msp_host_model.sel(1'b1);
    acc(1'b0, 6'h05, 2'h3, 24'ha5c31e);
    check(rx, 24'ha5c31e, "read data");
    check(acc_addr, 6'h05, "address");
    check(read_ones_sum, 6'h0c, "ones count");
    repeat (4) @(posedge clock);
    check(dout_oe_n, 1'b1, "release after last bit");
    acc(1'b0, 6'h11, 2'h1, 24'h000007);
    check(rx, 24'h000007, "second read");
    exp_sum = read_ones_sum;
    check(exp_sum, 6'h03, "ones count reloaded");
    acc(1'b0, msp_pkg::CKSUM_ADDR, 2'h1, 24'(exp_sum));
    check(rx, 24'h000003, "count read");
    check(read_ones_sum, 6'h02, "count of count");
    $display("test reads done");

    // Writes pile up while the core stalls, then drain in order
    acc(1'b1, 6'h21, 2'h3, 24'h123456);
    acc(1'b1, 6'h0a, 2'h1, 24'h0000c9);
    check(wr_valid, 1'b1, "bytes held");
    check(got.size(), 0, "nothing taken while stalled");
    @(posedge clock);
    wr_ready <= 1'b1;
    wait_got(4);
    for (int i = 0; i < 4; i++) begin
      check(got[i], exp_w[i], "write byte");
    end
    $display("test writes done");

    // Write cut short in its data byte is dropped
    base = got.size();
    i_msp_host_model.xbyte({1'b1, 1'b0, 6'h0c}, b);
    for (int i = 0; i < 4; i++) begin
      i_msp_host_model.xbit(1'b1, b[0]);
    end
    i_msp_host_model.sel(1'b0);
    repeat (20) @(posedge clock);
    check(got.size(), base, "partial byte dropped");

    // Read cut short releases output and leaves a partial count
    i_msp_host_model.sel(1'b1);
    core_len <= 2'h3;
    core_val <= 24'hffffff;
    i_msp_host_model.xbyte({1'b0, 1'b0, 6'h05}, b);
    for (int i = 0; i < 5; i++) begin
      i_msp_host_model.xbit(1'b0, b[0]);
    end
    i_msp_host_model.sel(1'b0);
    check(dout_oe_n, 1'b1, "release on deselect");
    check(read_ones_sum, 6'h05, "partial count");
    i_msp_host_model.sel(1'b1);
    acc(1'b0, 6'h02, 2'h1, 24'h00003c);
    check(rx, 24'h00003c, "read after new select");
    $display("test aborts done");

    // Reset with select held low: synchronised select restarts high, so the port idles, then its fall gives command mode
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    acc(1'b0, 6'h07, 2'h2, 24'h00b00f);
    check(rx, 24'h00b00f, "read after reset");
    // A core reporting length zero is read as one byte
    @(posedge clock);
    core_len <= 2'h0;
    core_val <= 24'h000081;
    i_msp_host_model.access(1'b0, 6'h03, 1, 24'h000000, rx);
    check(rx, 24'h000081, "zero length read as one byte");
    check(read_ones_sum, 6'h02, "count of short read");
    $display("test tied select done");
    results();
  end
endmodule
